// *** fsc_fuse_bank.sv ***
`timescale 1ns/1ns

// One array of one-time-programmable bits; a burn can only set bits.
module fsc_fuse_bank #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  input  wire logic             burn_in,
  input  wire logic [WIDTH-1:0] burn_mask_in,
  output logic      [WIDTH-1:0] fuse_out
);

  logic [WIDTH-1:0] fuse_q;  // Fuse state, one flop per bit.
  logic [WIDTH-1:0] fuse_d;  // Next fuse state.

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A bit only ever goes from blank to set; a zero in the mask leaves it alone.
      always_comb begin
        fuse_d[i] = fuse_q[i] | (burn_in & burn_mask_in[i]);  // RQ10
      end
    end
  endgenerate

  // Register the fuse bits; reset stands for the blank part at power-up.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      fuse_q <= '0;
    end else begin
      fuse_q <= fuse_d;
    end
  end

  assign fuse_out = fuse_q;

endmodule

// *** fsc_host_model.sv ***
`timescale 1ns/1ns

// Programming host on the far side: issues one command at a time and waits for its answer.
module fsc_host_model #(
  parameter int KEY_W  = 256,
  parameter int USER_W = 32,
  parameter int CTRL_W = 6
) (
  input  wire logic         mclk_in,
  input  wire logic         cmd_ready_in,
  input  wire logic         cmd_done_in,
  input  wire logic         cmd_refused_in,
  output logic              cmd_valid_out,
  output logic [2:0]        cmd_op_out,
  output logic [KEY_W-1:0]  key_data_out,
  output logic [USER_W-1:0] user_data_out,
  output logic              user_low_given_out,
  output logic [CTRL_W-1:0] ctrl_data_out
);
  // Idle lines at time zero.
  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 3'h0;
    key_data_out = '0;
    user_data_out = '0;
    user_low_given_out = 1'b0;
    ctrl_data_out = '0;
  end

  // Holds the request until the edge where ready is seen, then scrambles the released op and data lines, all but user_low_given_out.
  task automatic run(input logic [2:0] op, input logic [KEY_W-1:0] k, input logic [USER_W-1:0] u,
                     input logic lg, input logic [CTRL_W-1:0] c, output logic ok, output logic rf);
    int n;
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_op_out = op;
    key_data_out = k;
    user_data_out = u;
    user_low_given_out = lg;
    ctrl_data_out = c;
    do @(posedge mclk_in); while (cmd_ready_in !== 1'b1);
    #1;
    cmd_valid_out = 1'b0;
    cmd_op_out = ~op;
    key_data_out = ~k;
    user_data_out = ~u;
    ctrl_data_out = ~c;
    for (n = 0; n < 200 && cmd_done_in !== 1'b1 && cmd_refused_in !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    ok = cmd_done_in;
    rf = cmd_refused_in;
  endtask
endmodule

// *** fsc_params.svh ***
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// Fuse array widths.
`define FSC_KEY_W        256
`define FSC_USER_W       32
`define FSC_USER_LOW_W   8
`define FSC_CTRL_W       6

// Control word bit positions.
`define FSC_FORCE_KEY_BIT   0
`define FSC_PR_BLOCK_BIT    1
`define FSC_KU_WLOCK_BIT    2
`define FSC_KEY_RLOCK_BIT   3
`define FSC_USER_RLOCK_BIT  4
`define FSC_CTRL_WLOCK_BIT  5

// Value of a blank fuse array.
`define FSC_CTRL_RESET   6'h00
`define FSC_USER_RESET   32'h0000_0000

// Mask that keeps the upper user bits, which a separate user program may burn.
`define FSC_USER_HI_MASK 32'hffff_ff00

// Timing: clock rate in Hz and fuse burn time in microseconds.
`define FSC_CLK_HZ       10000000
`define FSC_BURN_US      10
`define FSC_US_CYCLES    ((`FSC_CLK_HZ) / 1000000)

`endif

// *** fsc_pkg.sv ***
package fsc_pkg;

  // Commands on the fuse access port.
  typedef enum logic [2:0] {
    FSC_CMD_PROG_KEY  = 3'h0,
    FSC_CMD_PROG_USER = 3'h1,
    FSC_CMD_PROG_CTRL = 3'h2,
    FSC_CMD_READ_KEY  = 3'h3,
    FSC_CMD_READ_USER = 3'h4,
    FSC_CMD_READ_CTRL = 3'h5
  } fsc_cmd_t;

  // Sequencer states.
  typedef enum logic [0:0] {
    FSC_ST_IDLE,
    FSC_ST_BURN
  } fsc_state_t;

endpackage

// *** fsc_top.sv ***
// Summary of operation
// RQ1: Stored-key lock forbids any external decryption key.
// RQ2: Partial reconfiguration lock rejects every attempt.
// RQ3: Key/user write lock ignores key and user programming.
// RQ4: Key read lock blocks key readback.
// RQ5: User read lock blocks user word readback.
// RQ6: Control write lock freezes the control word.
// RQ7: Key programming also burns user low byte; the code burns it only when a pattern is given and the byte is still open.
// RQ8: Key burned without low byte locks it.
// RQ9: Upper 24 user bits programmable later too.
// RQ10: Programming only sets fuse bits, never clears.
`timescale 1ns/1ns
`include "fsc_params.svh"

module fsc_top #(
  parameter int KEY_W   = `FSC_KEY_W,
  parameter int USER_W  = `FSC_USER_W,
  parameter int CTRL_W  = `FSC_CTRL_W,
  parameter int BURN_US = `FSC_BURN_US
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_n_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [2:0]        cmd_op_in,
  input  wire logic [KEY_W-1:0]  key_data_in,
  input  wire logic [USER_W-1:0] user_data_in,
  input  wire logic              user_low_given_in,
  input  wire logic [CTRL_W-1:0] ctrl_data_in,
  input  wire logic              ext_key_sel_in,
  input  wire logic [KEY_W-1:0]  ext_key_in,
  input  wire logic              pr_req_in,
  output logic                   cmd_ready_out,
  output logic                   cmd_done_out,
  output logic                   cmd_refused_out,
  output logic [KEY_W-1:0]       rd_key_out,
  output logic [USER_W-1:0]      rd_word_out,
  output logic [KEY_W-1:0]       decrypt_key_out,
  output logic                   key_src_refused_out,
  output logic                   pr_grant_out,
  output logic                   pr_reject_out,
  output logic [CTRL_W-1:0]      ctrl_word_out
);

  // Cycles in one microsecond, and the last divider count and the last burn count (burn length in microseconds minus one).
  localparam int US_CYCLES = `FSC_US_CYCLES;
  localparam logic [15:0] US_LAST   = 16'(US_CYCLES - 1);
  localparam logic [15:0] BURN_LAST = 16'(BURN_US - 1);

  // Fuse contents seen from the fuse banks.
  logic [KEY_W-1:0]  key_fuse;          // Stored encryption key.
  logic [USER_W-1:0] user_fuse;         // User word.
  logic [CTRL_W-1:0] ctrl_fuse;         // Control word of lock bits.
  logic              low_lock_fuse;     // Set once the user low byte is closed.

  // Sequencer state.
  fsc_pkg::fsc_state_t state_q;         // Current state.
  fsc_pkg::fsc_state_t state_d;         // Next state.
  logic [15:0]       us_cnt_q;          // Divider count inside one microsecond.
  logic [15:0]       us_cnt_d;          // Next divider count.
  logic [15:0]       burn_cnt_q;        // Microseconds of burn elapsed.
  logic [15:0]       burn_cnt_d;        // Next burn count.
  logic              us_tick;           // One-cycle enable each microsecond.
  // Burn masks held for the length of a burn.
  logic [KEY_W-1:0]  pend_key_q;        // Key bits to set.
  logic [KEY_W-1:0]  pend_key_d;        // Next key mask.
  logic [USER_W-1:0] pend_user_q;       // User bits to set.
  logic [USER_W-1:0] pend_user_d;       // Next user mask.
  logic [CTRL_W-1:0] pend_ctrl_q;       // Control bits to set.
  logic [CTRL_W-1:0] pend_ctrl_d;       // Next control mask.
  logic              pend_low_lock_q;   // Close the user low byte.
  logic              pend_low_lock_d;   // Next low byte close.
  logic              burn;              // Fuse burn strobe at the end of a burn.
  // Access port answers.
  logic              ready_q;           // Port accepts a command.
  logic              ready_d;           // Next ready.
  logic              done_q;            // Command completed.
  logic              done_d;            // Next done.
  logic              refused_q;         // Command refused by a lock or as an unknown code.
  logic              refused_d;         // Next refused.
  logic [KEY_W-1:0]  rd_key_q;          // Key read result.
  logic [KEY_W-1:0]  rd_key_d;          // Next key read result.
  logic [USER_W-1:0] rd_word_q;         // User or control read result.
  logic [USER_W-1:0] rd_word_d;         // Next word read result.
  // Security outputs toward the configuration logic.
  logic [KEY_W-1:0]  dec_key_q;         // Key handed to the decryptor.
  logic [KEY_W-1:0]  dec_key_d;         // Next decryptor key.
  logic              key_ref_q;         // External key request refused.
  logic              key_ref_d;         // Next key refusal.
  logic              pr_grant_q;        // Partial reconfiguration allowed.
  logic              pr_grant_d;        // Next grant.
  logic              pr_reject_q;       // Partial reconfiguration rejected.
  logic              pr_reject_d;       // Next reject.
  logic [CTRL_W-1:0] ctrl_out_q;        // Registered copy of the control word.
  // Test one lock bit of the control word.
  function automatic logic lock_set(input logic [CTRL_W-1:0] ctrl, input int pos);
    lock_set = ctrl[pos];
  endfunction

  // Fuse arrays.
  fsc_fuse_bank #(.WIDTH(KEY_W)) u_key (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .burn_in(burn), .burn_mask_in(pend_key_q), .fuse_out(key_fuse));
  fsc_fuse_bank #(.WIDTH(USER_W)) u_user (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .burn_in(burn), .burn_mask_in(pend_user_q), .fuse_out(user_fuse));
  fsc_fuse_bank #(.WIDTH(CTRL_W)) u_ctrl (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .burn_in(burn), .burn_mask_in(pend_ctrl_q), .fuse_out(ctrl_fuse));
  fsc_fuse_bank #(.WIDTH(1)) u_low_lock (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .burn_in(burn), .burn_mask_in(pend_low_lock_q), .fuse_out(low_lock_fuse));

  // Microsecond divider runs only during a burn so the burn length is exact.
  assign us_tick = (state_q == fsc_pkg::FSC_ST_BURN) && (us_cnt_q == US_LAST);
  // The fuses are burned in the cycle the last microsecond ends.
  assign burn = us_tick && (burn_cnt_q == BURN_LAST);

  // Command decode, lock checks and burn sequencing.
  always_comb begin
    state_d         = state_q;
    us_cnt_d        = us_cnt_q;
    burn_cnt_d      = burn_cnt_q;
    pend_key_d      = pend_key_q;
    pend_user_d     = pend_user_q;
    pend_ctrl_d     = pend_ctrl_q;
    pend_low_lock_d = pend_low_lock_q;
    ready_d         = ready_q;
    done_d          = 1'b0;
    refused_d       = 1'b0;
    rd_key_d        = rd_key_q;
    rd_word_d       = rd_word_q;
    case (state_q)
      fsc_pkg::FSC_ST_IDLE: begin
        // A command is taken only while the port is ready.
        if (cmd_valid_in && ready_q) begin
          case (fsc_pkg::fsc_cmd_t'(cmd_op_in))
            fsc_pkg::FSC_CMD_PROG_KEY: begin
              if (lock_set(ctrl_fuse, `FSC_KU_WLOCK_BIT)) begin
                refused_d = 1'b1;  // RQ3
              end else begin
                pend_key_d  = key_data_in;
                // Upper user bits may ride along with the key.
                pend_user_d = user_data_in & `FSC_USER_HI_MASK;  // RQ9
                // Low byte burns with the key when a pattern is given and still open.
                if (user_low_given_in && !low_lock_fuse) begin
                  pend_user_d[`FSC_USER_LOW_W-1:0] = user_data_in[`FSC_USER_LOW_W-1:0];  // RQ7
                end
                // Low byte can never be burned again after any key burn.
                pend_low_lock_d = 1'b1;  // RQ8
                pend_ctrl_d     = '0;
                state_d         = fsc_pkg::FSC_ST_BURN;
                ready_d         = 1'b0;
              end
            end
            fsc_pkg::FSC_CMD_PROG_USER: begin
              if (lock_set(ctrl_fuse, `FSC_KU_WLOCK_BIT)) begin
                refused_d = 1'b1;  // RQ3
              end else begin
                // A separate user burn reaches only the upper 24 bits.
                pend_key_d      = '0;
                pend_user_d     = user_data_in & `FSC_USER_HI_MASK;  // RQ9
                pend_ctrl_d     = '0;
                pend_low_lock_d = 1'b0;
                state_d         = fsc_pkg::FSC_ST_BURN;
                ready_d         = 1'b0;
              end
            end
            fsc_pkg::FSC_CMD_PROG_CTRL: begin
              if (lock_set(ctrl_fuse, `FSC_CTRL_WLOCK_BIT)) begin
                refused_d = 1'b1;  // RQ6
              end else begin
                pend_key_d      = '0;
                pend_user_d     = '0;
                pend_ctrl_d     = ctrl_data_in;
                pend_low_lock_d = 1'b0;
                state_d         = fsc_pkg::FSC_ST_BURN;
                ready_d         = 1'b0;
              end
            end
            fsc_pkg::FSC_CMD_READ_KEY: begin
              if (lock_set(ctrl_fuse, `FSC_KEY_RLOCK_BIT)) begin
                refused_d = 1'b1;  // RQ4
              end else begin
                rd_key_d = key_fuse;
                done_d   = 1'b1;
              end
            end
            fsc_pkg::FSC_CMD_READ_USER: begin
              if (lock_set(ctrl_fuse, `FSC_USER_RLOCK_BIT)) begin
                refused_d = 1'b1;  // RQ5
              end else begin
                rd_word_d = user_fuse;
                done_d    = 1'b1;
              end
            end
            fsc_pkg::FSC_CMD_READ_CTRL: begin
              // The control word is always readable, zero-extended.
              rd_word_d = {{(USER_W-CTRL_W){1'b0}}, ctrl_fuse};
              done_d    = 1'b1;
            end
            default: begin
              // Unknown command codes are refused.
              refused_d = 1'b1;
            end
          endcase
        end
      end
      fsc_pkg::FSC_ST_BURN: begin
        // Count microseconds until the burn time has passed.
        if (us_tick) begin
          us_cnt_d   = '0;
          burn_cnt_d = burn_cnt_q + 16'h0001;
        end else begin
          us_cnt_d = us_cnt_q + 16'h0001;
        end
        if (burn) begin
          state_d    = fsc_pkg::FSC_ST_IDLE;
          burn_cnt_d = '0;
          ready_d    = 1'b1;
          done_d     = 1'b1;
        end
      end
      default: begin
        state_d = fsc_pkg::FSC_ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // Register the sequencer and port answers.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_q         <= fsc_pkg::FSC_ST_IDLE;
      us_cnt_q        <= '0;
      burn_cnt_q      <= '0;
      pend_key_q      <= '0;
      pend_user_q     <= `FSC_USER_RESET;
      pend_ctrl_q     <= `FSC_CTRL_RESET;
      pend_low_lock_q <= 1'b0;
      ready_q         <= 1'b1;
      done_q          <= 1'b0;
      refused_q       <= 1'b0;
      rd_key_q        <= '0;
      rd_word_q       <= '0;
    end else begin
      state_q         <= state_d;
      us_cnt_q        <= us_cnt_d;
      burn_cnt_q      <= burn_cnt_d;
      pend_key_q      <= pend_key_d;
      pend_user_q     <= pend_user_d;
      pend_ctrl_q     <= pend_ctrl_d;
      pend_low_lock_q <= pend_low_lock_d;
      ready_q         <= ready_d;
      done_q          <= done_d;
      refused_q       <= refused_d;
      rd_key_q        <= rd_key_d;
      rd_word_q       <= rd_word_d;
    end
  end

  // Key source selection and partial reconfiguration gating.
  always_comb begin
    if (ext_key_sel_in && !lock_set(ctrl_fuse, `FSC_FORCE_KEY_BIT)) begin
      dec_key_d = ext_key_in;
      key_ref_d = 1'b0;
    end else begin
      // With the stored-key lock an external key is never passed on.
      dec_key_d = key_fuse;  // RQ1
      key_ref_d = ext_key_sel_in;  // RQ1
    end
    pr_grant_d  = pr_req_in && !lock_set(ctrl_fuse, `FSC_PR_BLOCK_BIT);  // RQ2
    pr_reject_d = pr_req_in && lock_set(ctrl_fuse, `FSC_PR_BLOCK_BIT);  // RQ2
  end

  // Register the security outputs.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      dec_key_q   <= '0;
      key_ref_q   <= 1'b0;
      pr_grant_q  <= 1'b0;
      pr_reject_q <= 1'b0;
      ctrl_out_q  <= `FSC_CTRL_RESET;
    end else begin
      dec_key_q   <= dec_key_d;
      key_ref_q   <= key_ref_d;
      pr_grant_q  <= pr_grant_d;
      pr_reject_q <= pr_reject_d;
      ctrl_out_q  <= ctrl_fuse;
    end
  end

  assign cmd_ready_out       = ready_q;
  assign cmd_done_out        = done_q;
  assign cmd_refused_out     = refused_q;
  assign rd_key_out          = rd_key_q;
  assign rd_word_out         = rd_word_q;
  assign decrypt_key_out     = dec_key_q;
  assign key_src_refused_out = key_ref_q;
  assign pr_grant_out        = pr_grant_q;
  assign pr_reject_out       = pr_reject_q;
  assign ctrl_word_out       = ctrl_out_q;

endmodule

// *** fsc_top_props.sv ***
`timescale 1ns/1ns

// Watches the command port, the lock outputs and the key and PR paths of the fuse block.
module fsc_top_props #(
  parameter int KEY_W   = 256,
  parameter int USER_W  = 32,
  parameter int CTRL_W  = 6,
  parameter int BURN_US = 1
) (
  input wire logic              mclk_in,
  input wire logic              reset_n_in,
  input wire logic              cmd_valid_in,
  input wire logic [2:0]        cmd_op_in,
  input wire logic              ext_key_sel_in,
  input wire logic              pr_req_in,
  input wire logic              cmd_ready_out,
  input wire logic              cmd_done_out,
  input wire logic              cmd_refused_out,
  input wire logic [KEY_W-1:0]  rd_key_out,
  input wire logic [USER_W-1:0] rd_word_out,
  input wire logic              key_src_refused_out,
  input wire logic              pr_grant_out,
  input wire logic              pr_reject_out,
  input wire logic [CTRL_W-1:0] ctrl_word_out
);
  // A command is taken on an edge where valid meets ready.
  wire logic taken;
  assign taken = cmd_valid_in && cmd_ready_out;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_ext_key_block: assert property (ext_key_sel_in && ctrl_word_out[0] |=> key_src_refused_out)
    else $error("external key accepted while stored key forced");
  a_pr_reject: assert property (pr_req_in && ctrl_word_out[1] |=> pr_reject_out && !pr_grant_out)
    else $error("partial reconfiguration not rejected");
  a_pr_idle: assert property (!pr_req_in |=> !pr_grant_out && !pr_reject_out)
    else $error("partial reconfiguration answer without request");
  a_key_wlock: assert property (taken && cmd_op_in inside {3'h0, 3'h1} && ctrl_word_out[2]
    |=> cmd_refused_out)
    else $error("key or user program not refused");
  a_key_rlock: assert property (taken && cmd_op_in == 3'h3 && ctrl_word_out[3]
    |=> cmd_refused_out && $stable(rd_key_out))
    else $error("key read not blocked");
  a_user_rlock: assert property (taken && cmd_op_in == 3'h4 && ctrl_word_out[4]
    |=> cmd_refused_out && $stable(rd_word_out))
    else $error("user read not blocked");
  a_ctrl_frozen: assert property (ctrl_word_out[5] |=> $stable(ctrl_word_out))
    else $error("control word changed after write lock");
  a_fuse_only_set: assert property ((ctrl_word_out & $past(ctrl_word_out))
    == $past(ctrl_word_out))
    else $error("control fuse bit cleared");
  a_ctrl_burn_time: assert property (taken && cmd_op_in == 3'h2
    && !ctrl_word_out[5] && !cmd_done_out
    |=> !cmd_ready_out [*8] ##3 (cmd_done_out && cmd_ready_out))
    else $error("control program timing wrong");

  // Main scenarios reached by the bench.
  c_pr_reject: cover property (pr_reject_out);
  c_refused: cover property (cmd_refused_out);
  c_key_forced: cover property (key_src_refused_out);
endmodule

bind fsc_top fsc_top_props #(.KEY_W(KEY_W), .USER_W(USER_W), .CTRL_W(CTRL_W), .BURN_US(BURN_US))
  chk_u (.mclk_in, .reset_n_in, .cmd_valid_in, .cmd_op_in, .ext_key_sel_in, .pr_req_in,
  .cmd_ready_out, .cmd_done_out, .cmd_refused_out, .rd_key_out, .rd_word_out,
  .key_src_refused_out, .pr_grant_out, .pr_reject_out, .ctrl_word_out);

// *** fsc_top_tb.sv ***
`timescale 1ns/1ns

// Self-checking bench for the fuse security block, burn shortened to ten cycles.
module fsc_top_tb;
  localparam logic [255:0] K1 = {8{32'h0f1e_2d3c}};
  localparam logic [255:0] K2 = {8{32'hc0a0_0101}};
  localparam logic [255:0] K3 = {8{32'h5555_aaaa}};

  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ext_key_sel_in = 1'b0;
  logic [255:0] ext_key_in = '0;
  logic pr_req_in = 1'b0;
  logic cmd_valid_in, user_low_given_in, cmd_ready_out, cmd_done_out, cmd_refused_out;
  logic key_src_refused_out, pr_grant_out, pr_reject_out;
  logic [2:0] cmd_op_in;
  logic [255:0] key_data_in, rd_key_out, decrypt_key_out;
  logic [31:0] user_data_in, rd_word_out;
  logic [5:0] ctrl_data_in, ctrl_word_out;
  int n_errors = 0;
  int samples_checked = 0;

  // 10 MHz clock.
  always #50 mclk_in = ~mclk_in;

  fsc_top #(.BURN_US(1)) dut_u (.mclk_in, .reset_n_in, .cmd_valid_in, .cmd_op_in, .key_data_in,
    .user_data_in, .user_low_given_in, .ctrl_data_in, .ext_key_sel_in, .ext_key_in, .pr_req_in,
    .cmd_ready_out, .cmd_done_out, .cmd_refused_out, .rd_key_out, .rd_word_out,
    .decrypt_key_out, .key_src_refused_out, .pr_grant_out, .pr_reject_out, .ctrl_word_out);

  fsc_host_model host_u (.mclk_in, .cmd_ready_in(cmd_ready_out), .cmd_done_in(cmd_done_out),
    .cmd_refused_in(cmd_refused_out), .cmd_valid_out(cmd_valid_in), .cmd_op_out(cmd_op_in),
    .key_data_out(key_data_in), .user_data_out(user_data_in),
    .user_low_given_out(user_low_given_in), .ctrl_data_out(ctrl_data_in));

  // Counts one comparison and reports a mismatch.
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Holds reset low for eight cycles, a blank part afterwards.
  task automatic rst;
    reset_n_in = 1'b0;
    repeat (8) @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
  endtask

  // One command; its answer must be done or refused as expected.
  task automatic cmd(input logic [2:0] op, input logic [255:0] k, input logic [31:0] u,
                     input logic lg, input logic [5:0] c, input logic xrf);
    logic ok, rf;
    host_u.run(op, k, u, lg, c, ok, rf);
    check("answer", {254'h0, ok, rf}, {254'h0, ~xrf, xrf});
  endtask

  // One read; the read result must hold the expected value afterwards.
  task automatic rd(input logic [2:0] op, input logic xrf, input logic [255:0] exp);
    cmd(op, '0, '0, 1'b0, '0, xrf);
    check("read", (op == 3'h3) ? rd_key_out : 256'(rd_word_out), exp);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge mclk_in);
    n_errors++;
    $display("watchdog expired");
    results();
  end

  initial begin
    rst();
    check("ctrl_word", 256'(ctrl_word_out), '0);
    cmd(3'h0, K1, 32'h0000_00a5, 1'b0, '0, 1'b0);
    cmd(3'h0, K1, 32'h0000_00a5, 1'b1, '0, 1'b0);
    cmd(3'h1, '0, 32'h0000_00a5, 1'b0, '0, 1'b0);
    cmd(3'h7, K3, 32'hffff_ffff, 1'b1, 6'h3f, 1'b1);
    rd(3'h5, 1'b0, '0);
    rd(3'h4, 1'b0, '0);
    $display("test key_without_pattern finished");

    rst();
    cmd(3'h0, K1, 32'h1234_56a5, 1'b1, '0, 1'b0);
    rd(3'h3, 1'b0, K1);
    rd(3'h4, 1'b0, 32'h1234_56a5);
    cmd(3'h0, K2, 32'h0000_005a, 1'b1, '0, 1'b0);
    rd(3'h3, 1'b0, K1 | K2);
    cmd(3'h1, '0, 32'h8000_00ff, 1'b0, '0, 1'b0);
    rd(3'h4, 1'b0, 32'h9234_56a5);
    $display("test key_and_user finished");

    @(posedge mclk_in);
    #1;
    ext_key_sel_in = 1'b1;
    ext_key_in = K3;
    pr_req_in = 1'b1;
    @(posedge mclk_in);
    #1;
    check("decrypt_key", decrypt_key_out, K3);
    check("pr_grant", {pr_grant_out, pr_reject_out}, 2'h2);
    cmd(3'h2, '0, '0, 1'b0, 6'h1f, 1'b0);
    @(posedge mclk_in);
    #1;
    check("decrypt_key", decrypt_key_out, K1 | K2);
    check("key_src_refused", key_src_refused_out, 1'b1);
    check("pr_reject", {pr_grant_out, pr_reject_out}, 2'h1);
    rd(3'h3, 1'b1, K1 | K2);
    rd(3'h4, 1'b1, 32'h9234_56a5);
    cmd(3'h0, K3, 32'hffff_ffff, 1'b1, '0, 1'b1);
    cmd(3'h1, '0, 32'hffff_ffff, 1'b0, '0, 1'b1);
    rd(3'h5, 1'b0, 6'h1f);
    cmd(3'h2, '0, '0, 1'b0, 6'h20, 1'b0);
    cmd(3'h2, '0, '0, 1'b0, 6'h3f, 1'b1);
    rd(3'h5, 1'b0, 6'h3f);
    pr_req_in = 1'b0;
    @(posedge mclk_in);
    #1;
    check("pr_idle", {pr_grant_out, pr_reject_out}, 2'h0);
    check("ctrl_word", 256'(ctrl_word_out), 6'h3f);
    $display("test locks finished");
    results();
  end
endmodule
